/* logic/pfid_regs.sv */
// read-only architecture revision and cache capacity identification registers
module pfid_regs
	import pfid_pkg::*;
#(
	parameter pfid_level_type LEVEL = PFID_LVL_POINT_ONE,
	parameter bit FEATURE_PRESENT = 1'b1,
	parameter bit INST_SELECT = 1'b1,
	// per frame/instance: {softlim, nocmax, cmin, cassoc, cassoc_wd[4:0], cmax_wd[5:0]}
	parameter logic [PFID_NFRAME*PFID_NINST*PFID_DESC_W-1:0] CAP_TABLE = {16{15'b1000_0000_0000_100}}
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// feature register inputs
	input wire logic capacity_partition_present,
	input wire logic [PFID_INST_W-1:0] resource_instance_select,
	// register access
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [1:0] frame_sel,
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata_q,
	output logic rvalid_q,
	// partition identifier forcing for secure requests
	input wire logic req_secure,
	output logic forced_nonsecure_partition
);
	logic [PFID_REV_W-1:0] major_revision_field;
	logic [PFID_REV_W-1:0] minor_revision_field;
	logic [31:0] arch_word;
	logic [PFID_DESC_W-1:0] desc_q;
	logic flags_live;
	logic [31:0] cap_word;
	logic rd_arch_q;
	logic rd_cap_q;
	logic [PFID_INST_W-1:0] inst_eff;
	logic unused_wr;
	logic [7:0] rev_code;

	// level to revision pairing
	function automatic logic [7:0] level_code(input pfid_level_type lv);
		unique case (lv)
			PFID_LVL_NONE: level_code = {4'h0, 4'h0};
			PFID_LVL_EARLY: level_code = {4'h0, 4'h1};
			PFID_LVL_BASE: level_code = {4'h1, 4'h0};
			PFID_LVL_POINT_ONE: level_code = {4'h1, 4'h1};
		endcase
	endfunction

	assign rev_code = level_code(LEVEL);
	assign major_revision_field = FEATURE_PRESENT ? rev_code[7:4] : 4'h0;
	assign minor_revision_field = FEATURE_PRESENT ? rev_code[3:0] : 4'h0;
	// frame does not enter this word, so all copies match
	assign arch_word = {24'h00_0000, major_revision_field, minor_revision_field};

	// forcing is a fixed property, no register controls or shows it
	assign forced_nonsecure_partition = FEATURE_PRESENT && (LEVEL == PFID_LVL_EARLY) && req_secure;

	assign inst_eff = INST_SELECT ? resource_instance_select : '0;

	pfid_desc_rom #(
		.TABLE(CAP_TABLE)
	) u_rom (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.frame(frame_sel),
		.inst(inst_eff),
		.desc_q(desc_q)
	);

	assign flags_live = (LEVEL == PFID_LVL_EARLY) || (LEVEL == PFID_LVL_POINT_ONE);

	always_comb begin
		cap_word = 32'h0000_0000;
		cap_word[PFID_CMAX_WD_LSB +: PFID_CMAX_WD_W] = desc_q[5:0];
		if (flags_live) begin
			cap_word[PFID_SOFTLIM_BIT] = desc_q[14];
			cap_word[PFID_NOCMAX_BIT] = desc_q[13];
			cap_word[PFID_CMIN_BIT] = desc_q[12];
			cap_word[PFID_CASSOC_BIT] = desc_q[11];
			cap_word[PFID_CASSOC_WD_LSB +: PFID_CASSOC_WD_W] = desc_q[10:6];
		end
	end

	// address decode, same offsets in every frame
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rd_arch_q <= 1'b0;
			rd_cap_q <= 1'b0;
		end else if (clk_en) begin
			rd_arch_q <= rd_en && (addr == PFID_ARCH_OFF);
			rd_cap_q <= rd_en && (addr == PFID_CCAP_OFF) && FEATURE_PRESENT && capacity_partition_present;
		end
	end

	// read data one cycle after table lookup
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdata_q <= PFID_RDATA_RST;
			rvalid_q <= 1'b0;
		end else if (clk_en) begin
			rvalid_q <= rd_arch_q || rd_cap_q || (rvalid_q && 1'b0);
			if (rd_arch_q) begin
				rdata_q <= arch_word;
			end else if (rd_cap_q) begin
				rdata_q <= cap_word;
			end else begin
				rdata_q <= PFID_RDATA_RST;
			end
		end
	end

	// writes have no effect on any state
	assign unused_wr = wr_en ^ (^wdata);
endmodule

/* include/pfid_pkg.sv */
// package of constants for the partition feature identification registers
package pfid_pkg;
	// register offsets within each feature frame
	localparam logic [11:0] PFID_ARCH_OFF = 12'h0020;
	localparam logic [11:0] PFID_CCAP_OFF = 12'h0038;
	// field positions of the architecture revision register
	localparam int PFID_MAJOR_LSB = 4;
	localparam int PFID_MINOR_LSB = 0;
	localparam int PFID_REV_W = 4;
	// field positions of the cache capacity register
	localparam int PFID_SOFTLIM_BIT = 31;
	localparam int PFID_NOCMAX_BIT = 30;
	localparam int PFID_CMIN_BIT = 29;
	localparam int PFID_CASSOC_BIT = 28;
	localparam int PFID_CASSOC_WD_LSB = 8;
	localparam int PFID_CASSOC_WD_W = 5;
	localparam int PFID_CMAX_WD_LSB = 0;
	localparam int PFID_CMAX_WD_W = 6;
	// reset value of read data
	localparam logic [31:0] PFID_RDATA_RST = 32'h0000_0000;
	// number of feature frames and resource instances
	localparam int PFID_NFRAME = 4;
	localparam int PFID_NINST = 4;
	localparam int PFID_INST_W = 2;
	// per-instance capacity description width
	localparam int PFID_DESC_W = 15;
	// feature frames
	typedef enum logic [1:0] {
		PFID_FRAME_SECURE = 2'b00,
		PFID_FRAME_NONSECURE = 2'b01,
		PFID_FRAME_ROOT = 2'b10,
		PFID_FRAME_REALM = 2'b11
	} pfid_frame_type;
	// permitted architecture levels
	typedef enum logic [1:0] {
		PFID_LVL_NONE = 2'b00,
		PFID_LVL_EARLY = 2'b01,
		PFID_LVL_BASE = 2'b10,
		PFID_LVL_POINT_ONE = 2'b11
	} pfid_level_type;
endpackage

/* logic/pfid_desc_rom.sv */
// table of per-frame, per-instance capacity descriptions with registered read
module pfid_desc_rom
	import pfid_pkg::*;
#(
	parameter logic [PFID_NFRAME*PFID_NINST*PFID_DESC_W-1:0] TABLE = '0
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// lookup
	input wire logic [1:0] frame,
	input wire logic [PFID_INST_W-1:0] inst,
	output logic [PFID_DESC_W-1:0] desc_q
);
	logic [3:0] idx;
	assign idx = {frame, inst};

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			desc_q <= '0;
		end else if (clk_en) begin
			desc_q <= TABLE[idx*PFID_DESC_W +: PFID_DESC_W];
		end
	end
endmodule

/* verif/pfid_regs_sva.sv */
// assertions on the identification register ports
module pfid_regs_sva (
	// watched ports
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic capacity_partition_present,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [11:0] addr,
	input wire logic [31:0] rdata_q,
	input wire logic rvalid_q,
	input wire logic req_secure,
	input wire logic forced_nonsecure_partition
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	sequence arch_rd;
		rd_en && addr == 12'h020;
	endsequence
	sequence cap_rd;
		rd_en && addr == 12'h038;
	endsequence
	a_arch_value: assert property (arch_rd |-> ##2 rvalid_q && rdata_q == 32'h0000_0011)
		else $error("bad revision word");
	a_upper_zero: assert property (rvalid_q && $past(addr, 2) == 12'h020 |-> rdata_q[31:8] == 24'h00_0000)
		else $error("revision upper bits set");
	a_cap_value: assert property (cap_rd ##0 capacity_partition_present |-> ##2 rvalid_q && rdata_q == 32'h8000_0004)
		else $error("bad capacity word");
	a_cap_absent: assert property (cap_rd ##0 !capacity_partition_present |-> ##2 !rvalid_q)
		else $error("absent capacity answered");
	a_nocmax_flag: assert property (rvalid_q && $past(addr, 2) == 12'h038 |-> !rdata_q[30])
		else $error("capacity control flagged absent");
	a_valid_cause: assert property (rvalid_q |-> $past(rd_en, 2))
		else $error("answer without read");
	a_write_quiet: assert property (wr_en && !rd_en |-> ##2 !rvalid_q)
		else $error("write answered");
	a_idle_zero: assert property (!rvalid_q |-> rdata_q == 32'h0000_0000)
		else $error("data without valid");
	a_no_force: assert property (req_secure |-> !forced_nonsecure_partition)
		else $error("forcing at point-one level");
endmodule
bind pfid_regs pfid_regs_sva pfid_regs_sva_i (.*);

/* verif/tb.sv */
// self-checking bench for the identification registers
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, sys_rst = 1, clk_en = 1, capacity_partition_present = 0, rd_en = 0, wr_en = 0, req_secure = 0;
	logic [1:0] resource_instance_select = 0, frame_sel = 0;
	logic [11:0] addr = 0;
	logic [31:0] wdata = 0, rdata_q, s = 80;
	logic rvalid_q, forced_nonsecure_partition;
	logic [32:0] exp_q [4];
	int err_count = 0, num_checks = 0, cyc = 0;
	pfid_regs pfid_regs_i (.*);
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			final_report();
		end
	end
	function logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function logic [32:0] exp_word(logic rd, logic [11:0] a, logic cp);
		if (rd && a == 12'h020) return {1'b1, 32'h0000_0011};
		if (rd && a == 12'h038 && cp) return {1'b1, 32'h8000_0004};
		return 33'h0_0000_0000;
	endfunction
	task check(string name, logic [32:0] e, logic [32:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", name, e, g);
		end
	endtask
	task final_report();
		$display("errors %0d checks %0d", err_count, num_checks);
		if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		logic [31:0] r;
		for (int i = 0; i < 4; i++) exp_q[i] = 0;
		repeat (8) @(posedge mclk);
		#1 sys_rst = 0;
		for (int k = 0; k < 400; k++) begin
			@(posedge mclk);
			#1 check("read", exp_q[(k + 2) % 4], {rvalid_q, rdata_q});
			check("force", 33'h0_0000_0000, {32'h0000_0000, forced_nonsecure_partition});
			r = rnd();
			rd_en = r[0];
			wr_en = r[1];
			addr = r[3:2] == 0 ? 12'h020 : r[3:2] == 1 ? 12'h038 : r[3:2] == 2 ? 12'h03C : r[31:20];
			capacity_partition_present = r[4];
			frame_sel = r[6:5];
			resource_instance_select = r[8:7];
			req_secure = r[9];
			wdata = rnd();
			// back-to-back reads with writes, every frame
			if (k < 8) begin
				rd_en = 1;
				wr_en = 1;
				capacity_partition_present = 1;
				addr = k[0] ? 12'h038 : 12'h020;
				frame_sel = k[2:1];
			end
			exp_q[k % 4] = exp_word(rd_en, addr, capacity_partition_present);
		end
		final_report();
	end
endmodule
